// ===== rtl/mrf_pkg.sv
// mrf_pkg: field layout, codes and reset values for register field control
// assumes one microcycle spans at least two clk cycles (mid and end edges)
package mrf_pkg;

	// microinstruction fields, as presented by the control store
	typedef struct packed {
		logic [3:0] slice_position_code;
		logic [8:0] next_address_field;
		logic [1:0] test_function;
		logic [1:0] sequencing_function;
		logic [3:0] general_function;
		logic       slice_top_bit_keep;
		logic [1:0] specifier_source_code;
		logic [3:0] memory_interrupt_code;
		logic [1:0] alu_b_input_select;
		logic [1:0] alu_a_input_select;
		logic [2:0] register_function_code;
		logic [3:0] alu_function_code;
		logic       alu_logic_mode_bit;
		logic [1:0] carry_field;
		logic       write_bit;
		logic       shift_count_bit;
		logic       force_source_choice;
		logic [1:0] extra_function;
		logic [2:0] shifter_control;
		logic [3:0] second_reg_specifier;
		logic [3:0] first_reg_specifier;
	} mrf_uinst_t;

	// datapath, memory and i/o conditions seen by the control logic
	typedef struct packed {
		logic [15:0] instruction_register;
		logic        operand_bit01;
		logic        alu_bit15;
		logic        io_request;
		logic        io_busy;
		logic        io_done_bit;
		logic        mem_busy;
		logic        mem_write_active;
		logic        interrupt_active;
		logic [3:0]  interrupt_nibble;
		logic [8:0]  decoder_address;
		logic        interrupt_flag_set;
		logic        byte_flag_set;
		logic        byte_flag_clear;
	} mrf_status_t;

	typedef enum logic [0:0] {
		MRF_FIRST_HALF,
		MRF_SECOND_HALF
	} mrf_phase_t;

	// field codes
	localparam logic [1:0] MRF_SF_ZERO      = 2'h0;
	localparam logic [1:0] MRF_TF_ZERO      = 2'h0;
	localparam logic [1:0] MRF_AB_CONTROL   = 2'h0;
	localparam logic [1:0] MRF_AB_TO_SECOND = 2'h1;
	localparam logic [1:0] MRF_AB_TO_FIRST  = 2'h2;
	localparam logic [1:0] MRF_AB_HOLD      = 2'h3;
	localparam logic [1:0] MRF_LB_SPECIAL   = 2'h2;
	localparam logic [3:0] MRF_IM_WAIT_MEM  = 4'h1;
	localparam logic [3:0] MRF_IM_WAIT_IO   = 4'h2;
	localparam logic [3:0] MRF_IM_INT_FLAG  = 4'h6;
	localparam logic [2:0] MRF_RF_INC_A     = 3'h4;
	localparam logic [2:0] MRF_RF_INC_B     = 3'h7;
	localparam logic [3:0] MRF_FORCE_HIGH   = 4'hf;
	localparam logic [3:0] MRF_FORCE_LOW    = 4'he;
	localparam logic [3:0] MRF_SPEC_MIR     = 4'h1;
	localparam logic [3:0] MRF_SPEC_ACC     = 4'h0;

	// field positions
	localparam int MRF_GF_IBUF_BIT   = 0;
	localparam int MRF_GF_DECODE_BIT = 2;
	localparam int MRF_IR_MODE_BIT   = 7;
	localparam int MRF_SLICE_WIDTH   = 4;

	// reset values
	localparam logic [3:0] MRF_SPEC_RESET  = 4'h0;
	localparam logic [8:0] MRF_ADDR_RESET  = 9'h000;
	localparam logic       MRF_FLAG_RESET  = 1'b0;

endpackage : mrf_pkg

// ===== rtl/mrf_slice_sel.sv
// mrf_slice_sel: picks a four-bit window of the instruction register
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
module mrf_slice_sel
	import mrf_pkg::*;
(
	input  wire logic [15:0] instruction_register,
	input  wire logic [2:0]  slice_position_code,
	input  wire logic        slice_top_bit_keep,
	output logic      [3:0]  slice_out
);
	logic [3:0] window;

	genvar i;
	generate
		for (i = 0; i < MRF_SLICE_WIDTH; i++) begin : g_bit
			// window slides up one bit per code step
			assign window[i] = instruction_register[{1'b0, slice_position_code} + 4'(i)]; // RULE_07
		end
	endgenerate

	assign slice_out = {window[3] & slice_top_bit_keep, window[2:0]}; // RULE_04
endmodule : mrf_slice_sel

// ===== rtl/mrf_phase_gen.sv
// mrf_phase_gen: splits each microcycle into a first and second half
// assumes stall is a level from the control logic, valid every cycle
`timescale 1ns/1ps
module mrf_phase_gen
	import mrf_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic stall,
	output logic      mid_pulse,
	output logic      end_pulse
);
	mrf_phase_t phase_q;
	mrf_phase_t phase_d;

	// a stall stretches the second half, so the end edge waits for it
	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			MRF_FIRST_HALF:  phase_d = MRF_SECOND_HALF;
			MRF_SECOND_HALF: if (!stall) phase_d = MRF_FIRST_HALF;
			default:         phase_d = MRF_FIRST_HALF;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			phase_q <= MRF_FIRST_HALF;
		else if (ce)
			phase_q <= phase_d;
	end

	assign mid_pulse = ce && (phase_q == MRF_FIRST_HALF);
	assign end_pulse = ce && (phase_q == MRF_SECOND_HALF) && !stall;
endmodule : mrf_phase_gen

// ===== rtl/mrf_control.sv
// mrf_control: control-buffer register specifiers and side controls
// assumes uinst and status stay stable for the whole microcycle
//
// Notes on behaviour
// RULE_01: source code 00 with mask 0 copies both specifiers from the microword.
// RULE_02: sequencing 00, no i/o: code 01 loads slice to second, 10 to first.
// RULE_03: the specifier not loaded from the slice keeps its last value.
// RULE_04: slice top bit forced zero when mask is 0, passed when mask is 1.
// RULE_05: code 11 with sequencing 00 and no i/o holds both specifiers.
// RULE_06: code 00, mask 1: hold first, force second to 1111/1110 from chosen bit.
// RULE_07: slice code n takes instruction register bits n+3 down to n.
// RULE_08: any i/o request suppresses every specifier load, hold and force.
// RULE_09: slice extraction runs independently of next-address field selection.
// RULE_10: test and sequencing zero with general bit 0 moves buffer into IR.
// RULE_11: jump to protection when b-select top 0, shift 0, extra 11 or 10.
// RULE_12: interrupt flag cleared when b-select 00/01 and extra 11 or 01.
// RULE_13: both input selects low and shifter top set: ALU mode from IR bit 7.
// RULE_14: ALU inputs sampled mid-cycle; addresses and most updates at the end.
// RULE_15: register function 100/111 bumps program counter at mid-cycle.
// RULE_16: byte address flag changes at mid-cycle to pick the altered byte.
// RULE_17: ALU controls steady during memory writes; wait-for-memory stalls.
// RULE_18: microprogram keeps ALU data two microwords for buffer transfers.
// RULE_19: stall on new i/o while busy, or wait-for-i/o until done.
// RULE_20: memory code 0110 selects and clears flag; interrupt replaces decode.
// RULE_21: general bit 2 enables decoder addressing and interrupt checking.
// RULE_22: b-select 10 picks special register by second; write goes to first.
`timescale 1ns/1ps
module mrf_control
	import mrf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire mrf_uinst_t  uinst,
	input  wire mrf_status_t status,
	output logic             stall,
	output logic             alu_sample_q,
	output logic             cycle_end_q,
	output logic [3:0]       first_spec_q,
	output logic [3:0]       second_spec_q,
	output logic [8:0]       next_address_q,
	output logic             ibuf_to_ir_q,
	output logic             jump_to_protect_q,
	output logic             interrupt_flag_q,
	output logic             pc_increment_q,
	output logic             byte_flag_q,
	output logic             special_alu_mode_q,
	output logic [3:0]       alu_function_q,
	output logic             alu_logic_mode_q,
	output logic [1:0]       carry_q,
	output logic             decoder_enable_q,
	output logic             interrupt_check_q,
	output logic             special_reg_sel_q,
	output logic             mir_selected_q,
	output logic             reg_write_q,
	output logic [3:0]       reg_write_addr_q,
	output logic             acc_write_q
);
	logic       mid_pulse;
	logic       end_pulse;
	logic [3:0] slice;
	logic [3:0] first_spec_d;
	logic [3:0] second_spec_d;
	logic [8:0] next_address_d;
	logic       interrupt_flag_d;
	logic       byte_flag_d;
	logic [3:0] alu_function_d;

	// decoded microword conditions
	wire sf_zero     = (uinst.sequencing_function == MRF_SF_ZERO);
	wire tf_zero     = (uinst.test_function == MRF_TF_ZERO);
	wire no_io       = !status.io_request;
	wire src_ctl     = (uinst.specifier_source_code == MRF_AB_CONTROL);
	wire src_second  = (uinst.specifier_source_code == MRF_AB_TO_SECOND);
	wire src_first   = (uinst.specifier_source_code == MRF_AB_TO_FIRST);
	wire keep_bit    = uinst.slice_top_bit_keep;
	wire slice_ok    = sf_zero && no_io;
	wire lb_low      = !uinst.alu_b_input_select[1];
	wire la_low      = !uinst.alu_a_input_select[1];
	wire force_bit   = uinst.force_source_choice ? status.operand_bit01
	                                             : status.alu_bit15;
	wire [3:0] force_val = force_bit ? MRF_FORCE_HIGH : MRF_FORCE_LOW;

	// stall sources
	wire wait_mem    = sf_zero && (uinst.memory_interrupt_code == MRF_IM_WAIT_MEM);
	wire wait_io     = sf_zero && (uinst.memory_interrupt_code == MRF_IM_WAIT_IO);
	assign stall     = (wait_mem && status.mem_busy) // RULE_17
	                || (status.io_request && status.io_busy) // RULE_19
	                || (wait_io && !status.io_done_bit); // RULE_19

	// side controls
	wire ibuf_move   = tf_zero && sf_zero
	                && uinst.general_function[MRF_GF_IBUF_BIT]; // RULE_10
	wire jump_sig    = lb_low && !uinst.shift_count_bit
	                && uinst.extra_function[1]; // RULE_11
	wire flag_clr_xf = lb_low && uinst.extra_function[0]; // RULE_12
	wire flag_select = sf_zero
	                && (uinst.memory_interrupt_code == MRF_IM_INT_FLAG); // RULE_20
	wire decode_en   = uinst.general_function[MRF_GF_DECODE_BIT]; // RULE_21
	wire take_int    = decode_en && status.interrupt_active
	                && !(flag_select && interrupt_flag_q); // RULE_20
	wire pc_inc      = (uinst.register_function_code == MRF_RF_INC_A)
	                || (uinst.register_function_code == MRF_RF_INC_B); // RULE_15
	wire special_alu = la_low && lb_low && uinst.shifter_control[2]; // RULE_13
	wire lb_special  = (uinst.alu_b_input_select == MRF_LB_SPECIAL); // RULE_22
	wire ir_mode     = status.instruction_register[MRF_IR_MODE_BIT];
	wire alu_frozen  = status.mem_write_active; // RULE_17

	// slice path shares no logic with next-address field selection
	mrf_slice_sel u_slice ( // RULE_09
		.instruction_register (status.instruction_register),
		.slice_position_code  (uinst.slice_position_code[2:0]),
		.slice_top_bit_keep   (keep_bit),
		.slice_out            (slice)
	);

	mrf_phase_gen u_phase (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.stall     (stall),
		.mid_pulse (mid_pulse),
		.end_pulse (end_pulse)
	);

	// specifier selection; i/o request overrides every function
	always_comb begin
		first_spec_d  = first_spec_q;
		second_spec_d = second_spec_q;
		if (status.io_request) begin
			first_spec_d  = first_spec_q; // RULE_08
			second_spec_d = second_spec_q; // RULE_08
		end else if (src_ctl && !keep_bit) begin
			first_spec_d  = uinst.first_reg_specifier; // RULE_01
			second_spec_d = uinst.second_reg_specifier; // RULE_01
		end else if (src_ctl && keep_bit) begin
			second_spec_d = force_val; // RULE_06
		end else if (slice_ok && src_second) begin
			second_spec_d = slice; // RULE_02 RULE_03
		end else if (slice_ok && src_first) begin
			first_spec_d  = slice; // RULE_02 RULE_03
		end
		// code 11 falls through and holds both // RULE_05
	end

	// interrupt priority over decoder, decoder over the address field
	assign next_address_d = take_int
	        ? {uinst.next_address_field[8:4], status.interrupt_nibble} // RULE_20
	        : decode_en ? status.decoder_address // RULE_21
	        : uinst.next_address_field;

	// hardware set wins over any clear in the same microcycle
	assign interrupt_flag_d = status.interrupt_flag_set ? 1'b1
	        : (flag_clr_xf || flag_select) ? 1'b0 // RULE_12 RULE_20
	        : interrupt_flag_q;

	assign byte_flag_d = status.byte_flag_set ? 1'b1
	        : status.byte_flag_clear ? 1'b0
	        : byte_flag_q;

	// low function bits come from the instruction in special mode
	assign alu_function_d = special_alu
	        ? {uinst.alu_function_code[3:2], ir_mode, !ir_mode} // RULE_13
	        : uinst.alu_function_code;

	// mid-cycle actions
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alu_sample_q   <= 1'b0;
			pc_increment_q <= 1'b0;
			byte_flag_q    <= MRF_FLAG_RESET;
		end else if (ce) begin
			alu_sample_q   <= mid_pulse; // RULE_14
			pc_increment_q <= mid_pulse && pc_inc; // RULE_15
			if (mid_pulse)
				byte_flag_q <= byte_flag_d; // RULE_16
		end
	end

	// ALU controls latched mid-cycle, frozen while a write is in flight
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alu_function_q     <= 4'h0;
			alu_logic_mode_q   <= 1'b0;
			carry_q            <= 2'h0;
			special_alu_mode_q <= 1'b0;
		end else if (ce && mid_pulse && !alu_frozen) begin
			alu_function_q     <= alu_function_d; // RULE_14 RULE_17
			alu_logic_mode_q   <= special_alu ? ir_mode
			                                  : uinst.alu_logic_mode_bit;
			carry_q            <= uinst.carry_field;
			special_alu_mode_q <= special_alu; // RULE_13
		end
	end

	// end-of-cycle state: specifiers, flag, next address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_spec_q     <= MRF_SPEC_RESET;
			second_spec_q    <= MRF_SPEC_RESET;
			next_address_q   <= MRF_ADDR_RESET;
			interrupt_flag_q <= MRF_FLAG_RESET;
		end else if (ce && end_pulse) begin
			first_spec_q     <= first_spec_d; // RULE_14
			second_spec_q    <= second_spec_d;
			next_address_q   <= next_address_d; // RULE_14
			interrupt_flag_q <= interrupt_flag_d;
		end else if (ce && status.interrupt_flag_set) begin
			interrupt_flag_q <= 1'b1;
		end
	end

	// end-of-cycle strobes, one clk wide
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cycle_end_q       <= 1'b0;
			ibuf_to_ir_q      <= 1'b0;
			jump_to_protect_q <= 1'b0;
			reg_write_q       <= 1'b0;
			acc_write_q       <= 1'b0;
			reg_write_addr_q  <= MRF_SPEC_RESET;
		end else if (ce) begin
			cycle_end_q       <= end_pulse;
			ibuf_to_ir_q      <= end_pulse && ibuf_move; // RULE_10
			jump_to_protect_q <= end_pulse && jump_sig; // RULE_11
			reg_write_q       <= end_pulse && uinst.write_bit; // RULE_22
			acc_write_q       <= end_pulse && uinst.write_bit
			                  && (first_spec_q == MRF_SPEC_ACC); // RULE_22
			if (end_pulse)
				reg_write_addr_q <= first_spec_q; // RULE_22
		end
	end

	// per-cycle levels, refreshed at mid-cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			decoder_enable_q  <= 1'b0;
			interrupt_check_q <= 1'b0;
			special_reg_sel_q <= 1'b0;
			mir_selected_q    <= 1'b0;
		end else if (ce && mid_pulse) begin
			decoder_enable_q  <= decode_en; // RULE_21
			interrupt_check_q <= decode_en; // RULE_21
			special_reg_sel_q <= lb_special; // RULE_22
			mir_selected_q    <= lb_special
			                  && (second_spec_q == MRF_SPEC_MIR); // RULE_22
		end
	end

	// ALU data held for buffer transfers is the microprogram's duty; RULE_18
endmodule : mrf_control

// ===== sim/mrf_control_asserts.sv
// mrf_control_asserts: port-level checks of specifiers and side controls
// assumes it is bound to mrf_control with ce held high
`timescale 1ns/1ps
module mrf_control_asserts
	import mrf_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire mrf_uinst_t  uinst,
	input wire mrf_status_t status,
	input wire logic        stall,
	input wire logic        alu_sample_q,
	input wire logic        cycle_end_q,
	input wire logic [3:0]  first_spec_q,
	input wire logic [3:0]  second_spec_q,
	input wire logic        ibuf_to_ir_q,
	input wire logic        jump_to_protect_q,
	input wire logic        interrupt_flag_q,
	input wire logic        pc_increment_q,
	input wire logic        decoder_enable_q,
	input wire logic        byte_flag_q,
	input wire logic [8:0]  next_address_q,
	input wire logic        special_alu_mode_q,
	input wire logic        acc_write_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] sh;
	logic [3:0]  slice;
	logic [1:0]  ab;
	logic        go;
	logic        sf0;
	assign sh    = status.instruction_register >> uinst.slice_position_code[2:0];
	assign slice = {sh[3] & uinst.slice_top_bit_keep, sh[2:0]};
	assign ab    = uinst.specifier_source_code;
	assign go    = !status.io_request;
	assign sf0   = uinst.sequencing_function == MRF_SF_ZERO;

	AST_COPY: assert property (cycle_end_q && $past(go && ab == 2'h0 &&
		!uinst.slice_top_bit_keep) |-> {first_spec_q, second_spec_q} ==
		$past({uinst.first_reg_specifier, uinst.second_reg_specifier}))
		else $error("specifiers not copied from microword");
	AST_IO_FREEZE: assert property (cycle_end_q && $past(status.io_request)
		|-> $stable(first_spec_q) && $stable(second_spec_q))
		else $error("specifiers changed during i/o request");
	AST_HOLD: assert property (cycle_end_q && $past(go && sf0 && ab == 2'h3)
		|-> $stable({first_spec_q, second_spec_q}))
		else $error("specifiers not held");
	AST_FORCE: assert property (cycle_end_q && $past(go && ab == 2'h0 &&
		uinst.slice_top_bit_keep) |-> $stable(first_spec_q) &&
		second_spec_q == {3'h7, $past(uinst.force_source_choice ?
		status.operand_bit01 : status.alu_bit15)})
		else $error("second specifier not forced");
	AST_SLICE: assert property (cycle_end_q && $past(go && sf0 && ab == 2'h1)
		|-> second_spec_q == $past(slice) && $stable(first_spec_q))
		else $error("slice not loaded into second specifier");
	AST_IBUF: assert property (cycle_end_q |-> ibuf_to_ir_q == $past(sf0 &&
		uinst.test_function == 2'h0 && uinst.general_function[0]))
		else $error("buffer transfer strobe wrong");
	AST_JUMP: assert property (cycle_end_q |-> jump_to_protect_q ==
		$past(!uinst.alu_b_input_select[1] && !uinst.shift_count_bit &&
		uinst.extra_function[1])) else $error("jump indication wrong");
	AST_FLAG_CLR: assert property (cycle_end_q &&
		$past(!status.interrupt_flag_set && (sf0 && uinst.memory_interrupt_code
		== MRF_IM_INT_FLAG || !uinst.alu_b_input_select[1] &&
		uinst.extra_function[0])) |-> !interrupt_flag_q)
		else $error("interrupt flag not cleared");
	AST_IO_WAIT: assert property (sf0 && uinst.memory_interrupt_code ==
		MRF_IM_WAIT_IO && !status.io_done_bit |-> stall)
		else $error("no stall while waiting for i/o");
	AST_PC_MID: assert property (alu_sample_q |-> pc_increment_q ==
		$past(uinst.register_function_code inside {3'h4, 3'h7}))
		else $error("program counter step wrong");
	AST_DECODE: assert property (alu_sample_q |-> decoder_enable_q ==
		$past(uinst.general_function[2])) else $error("decoder enable wrong");
	AST_END_AFTER_MID: assert property (alu_sample_q && !stall |=>
		cycle_end_q) else $error("microcycle end missing after mid");
	AST_BYTE_FLAG: assert property (alu_sample_q |-> byte_flag_q ==
		($past(status.byte_flag_set) ? 1'b1 : $past(status.byte_flag_clear)
		? 1'b0 : $past(byte_flag_q)))
		else $error("byte flag not updated at mid-cycle");
	AST_DECODE_ADDR: assert property (cycle_end_q &&
		$past(uinst.general_function[2] && !status.interrupt_active) |->
		next_address_q == $past(status.decoder_address))
		else $error("decoder address not taken");
	AST_SPECIAL_ALU: assert property (alu_sample_q &&
		$past(!status.mem_write_active) |-> special_alu_mode_q ==
		$past(!uinst.alu_a_input_select[1] && !uinst.alu_b_input_select[1]
		&& uinst.shifter_control[2]))
		else $error("special alu mode wrong");
	AST_ACC_WRITE: assert property (cycle_end_q |-> acc_write_q ==
		$past(uinst.write_bit && first_spec_q == 4'h0))
		else $error("accumulator write strobe wrong");
endmodule : mrf_control_asserts

bind mrf_control mrf_control_asserts mrf_control_asserts_i (.clk(clk),
	.rst(rst), .uinst(uinst), .status(status), .stall(stall),
	.alu_sample_q(alu_sample_q), .cycle_end_q(cycle_end_q),
	.first_spec_q(first_spec_q), .second_spec_q(second_spec_q),
	.ibuf_to_ir_q(ibuf_to_ir_q), .jump_to_protect_q(jump_to_protect_q),
	.interrupt_flag_q(interrupt_flag_q), .pc_increment_q(pc_increment_q),
	.decoder_enable_q(decoder_enable_q), .byte_flag_q(byte_flag_q),
	.next_address_q(next_address_q),
	.special_alu_mode_q(special_alu_mode_q), .acc_write_q(acc_write_q));

// ===== sim/mrf_store_model.sv
// mrf_store_model: memory and i/o interlock side seen by the control logic
// assumes one microword per microcycle; delay sets how slow it answers
`timescale 1ns/1ps
module mrf_store_model
	import mrf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire mrf_uinst_t uinst,
	input  wire logic [2:0] delay,
	output logic            mem_busy,
	output logic            io_busy,
	output logic            io_done_bit
);
	mrf_uinst_t prev_q;
	logic [2:0] cnt_q;
	// each new microword starts a transfer; zero delay answers at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= '0;
			cnt_q  <= 3'h0;
		end else begin
			prev_q <= uinst;
			cnt_q  <= (uinst != prev_q) ? delay : cnt_q - 3'(cnt_q != 3'h0);
		end
	end
	assign mem_busy    = cnt_q != 3'h0;
	assign io_busy     = cnt_q != 3'h0;
	assign io_done_bit = cnt_q == 3'h0;
endmodule : mrf_store_model

// ===== sim/mrf_control_bench.sv
// mrf_control_bench: self-checking bench for register field control
// assumes the store model answers memory and i/o interlocks
`timescale 1ns/1ps
`define MRF_CHECK(name, exp, got) begin n_compared++; \
	if ((got) !== (exp)) begin fail_count++; \
	$display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module mrf_control_bench
	import mrf_pkg::*;
;
	localparam int UW = $bits(mrf_uinst_t);
	localparam int SW = $bits(mrf_status_t);
	logic        clk, rst, ce, stall, alu_sample_q, cycle_end_q;
	logic        ibuf_to_ir_q, jump_to_protect_q, interrupt_flag_q;
	logic        mem_busy, io_busy, io_done_bit, ref_flag;
	logic [3:0]  first_spec_q, second_spec_q, ref_first, ref_second;
	logic [2:0]  delay;
	logic [10:0] e;
	logic [10:0] exp_q[$];
	logic [31:0] seed;
	int          fail_count, n_compared;
	mrf_uinst_t  uinst;
	mrf_status_t st, status;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always_comb begin
		status             = st;
		status.mem_busy    = mem_busy;
		status.io_busy     = io_busy;
		status.io_done_bit = io_done_bit;
	end
	mrf_control mrf_control_i (.clk(clk), .rst(rst), .ce(ce), .uinst(uinst),
		.status(status), .stall(stall), .alu_sample_q(alu_sample_q),
		.cycle_end_q(cycle_end_q), .first_spec_q(first_spec_q),
		.second_spec_q(second_spec_q), .next_address_q(),
		.ibuf_to_ir_q(ibuf_to_ir_q), .jump_to_protect_q(jump_to_protect_q),
		.interrupt_flag_q(interrupt_flag_q), .pc_increment_q(),
		.byte_flag_q(), .special_alu_mode_q(), .alu_function_q(),
		.alu_logic_mode_q(), .carry_q(), .decoder_enable_q(),
		.interrupt_check_q(), .special_reg_sel_q(), .mir_selected_q(),
		.reg_write_q(), .reg_write_addr_q(), .acc_write_q());
	mrf_store_model mrf_store_model_i (.clk(clk), .rst(rst), .uinst(uinst),
		.delay(delay), .mem_busy(mem_busy), .io_busy(io_busy),
		.io_done_bit(io_done_bit));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	// returns at the end edge, where the next microword may be presented
	task automatic wait_end();
		logic mid;
		mid = 1'b0;
		for (int k = 0; k < 60; k++) begin
			@(posedge clk);
			if (alu_sample_q === 1'b1)
				mid = 1'b1;
			if (mid && stall === 1'b0)
				return;
		end
		fail_count++;
		$display("[FAIL] microcycle end expected 1 seen 0");
		stop_test();
	endtask : wait_end
	task automatic step(input mrf_uinst_t u, input mrf_status_t s);
		logic [15:0] sh;
		logic [3:0]  sl;
		logic        go, sf0, ibuf, jmp;
		sh   = s.instruction_register >> u.slice_position_code[2:0];
		sl   = {sh[3] & u.slice_top_bit_keep, sh[2:0]};
		go   = !s.io_request;
		sf0  = u.sequencing_function == MRF_SF_ZERO;
		ibuf = sf0 && u.test_function == MRF_TF_ZERO && u.general_function[0];
		jmp  = !u.alu_b_input_select[1] && !u.shift_count_bit;
		jmp  = jmp && u.extra_function[1];
		if (go && u.specifier_source_code == MRF_AB_CONTROL) begin
			if (!u.slice_top_bit_keep)
				{ref_first, ref_second} = {u.first_reg_specifier,
					u.second_reg_specifier};
			else
				ref_second = {3'h7, u.force_source_choice ? s.operand_bit01 :
					s.alu_bit15};
		end else if (go && sf0 && u.specifier_source_code == MRF_AB_TO_SECOND)
			ref_second = sl;
		else if (go && sf0 && u.specifier_source_code == MRF_AB_TO_FIRST)
			ref_first = sl;
		if (s.interrupt_flag_set)
			ref_flag = 1'b1;
		else if (!u.alu_b_input_select[1] && u.extra_function[0] ||
			sf0 && u.memory_interrupt_code == MRF_IM_INT_FLAG)
			ref_flag = 1'b0;
		exp_q.push_back({ref_first, ref_second, ibuf, jmp, ref_flag});
		uinst <= u;
		st    <= s;
		delay <= 3'(rnd() & 32'h0000_0003);
		wait_end();
	endtask : step

	always @(posedge clk) begin
		if (cycle_end_q === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
			`MRF_CHECK("first", e[10:7], first_spec_q)
			`MRF_CHECK("second", e[6:3], second_spec_q)
			`MRF_CHECK("ibuf", e[2], ibuf_to_ir_q)
			`MRF_CHECK("jump", e[1], jump_to_protect_q)
			`MRF_CHECK("flag", e[0], interrupt_flag_q)
		end
	end

	initial begin
		mrf_uinst_t  u;
		mrf_status_t s;
		seed = 32'h0000_4435;
		{rst, ce, uinst, st, delay} = {2'h3, UW'(0), SW'(0), 3'h0};
		{fail_count, n_compared, ref_first, ref_second, ref_flag} = '0;
		exp_q.push_back(11'h000);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wait_end();
		for (int i = 0; i < 400; i++) begin
			u = UW'({rnd(), rnd()});
			s = SW'({rnd(), rnd()});
			s.io_request = s.io_request & s.byte_flag_set;
			if (i < 32) begin
				// walk every source code against every slice position
				u.sequencing_function      = MRF_SF_ZERO;
				u.specifier_source_code    = 2'(i);
				u.slice_position_code[2:0] = 3'(i >> 2);
				s.io_request               = 1'b0;
			end
			step(u, s);
			if (i == 31)
				$display("test slice and source walk done");
		end
		$display("test random microwords done");
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule : mrf_control_bench
